/* File: spsf_pkg.sv */
// Shared constants and types of the serial port status flag block
package spsf_pkg;

  localparam int NUM_CHAN = 4;
  localparam int ADDR_W = 16;
  localparam int IRQ_W = 2 * NUM_CHAN;

  // Status register of each channel
  localparam logic [15:0] SERIAL_A_STATUS = 16'h00c3;
  localparam logic [15:0] SERIAL_B_STATUS = 16'h00d3;
  localparam logic [15:0] SERIAL_C_STATUS = 16'h00e3;
  localparam logic [15:0] SERIAL_D_STATUS = 16'h00f3;
  localparam logic [15:0] STATUS_ADDR [NUM_CHAN] = '{
    SERIAL_A_STATUS, SERIAL_B_STATUS, SERIAL_C_STATUS, SERIAL_D_STATUS};

  // Offsets from a channel base (base is status address minus STAT_OFS), then the interrupt register addresses
  localparam logic [15:0] DATA_OFS = 16'h0000;
  localparam logic [15:0] STAT_OFS = 16'h0003;
  localparam logic [15:0] CTRL_OFS = 16'h0004;
  localparam logic [15:0] IRQ_STAT_ADDR = 16'h0100;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'h0101;

  // Status bit positions
  localparam int ST_RX_FULL = 7;
  localparam int ST_OVERRUN = 5;
  localparam int ST_TX_FULL = 3;
  localparam int ST_TX_BUSY = 2;

  // Control field positions
  localparam int CT_MODE_HI = 3;
  localparam int CT_MODE_LO = 2;
  localparam int CT_PRI_HI = 1;
  localparam int CT_PRI_LO = 0;
  localparam int CMD_RX_BIT = 6;
  localparam logic [7:0] CTRL_STORE_MASK = 8'h3f;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 8'h00;

  // Frame lengths and receive data widths in bits
  localparam logic [3:0] FRAME_A8 = 4'ha;
  localparam logic [3:0] FRAME_A7 = 4'h9;
  localparam logic [3:0] FRAME_SYNC = 4'h8;
  localparam logic [3:0] RX_BITS8 = 4'h8;
  localparam logic [3:0] RX_BITS7 = 4'h7;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int SCLK_HZ = 100_000;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int SCLK_HALF_CYCLES = CLK_HZ / (2 * SCLK_HZ);
  localparam int CNT_W = 11;

  typedef enum logic [1:0] {
    MODE_ASYNC8, MODE_ASYNC7, MODE_CLK_EXT, MODE_CLK_INT
  } spsf_mode_t;

endpackage : spsf_pkg

/* File: spsf_ser_if.sv */
// Link between the status logic and one channel's shifters
`timescale 1ns/1ps
`default_nettype none

interface spsf_ser_if;
  logic tx_have;
  logic [7:0] tx_byte;
  logic seven;
  logic clocked;
  logic shift_edge;
  logic sample_edge;
  logic tx_take;
  logic tx_busy;
  logic tx_line;
  logic rx_line;
  logic rx_go;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_busy;

  modport ctl (
    output tx_have, tx_byte, seven, clocked, shift_edge, sample_edge,
    output rx_line, rx_go,
    input tx_take, tx_busy, tx_line, rx_done, rx_byte, rx_busy
  );
  modport tx (
    input tx_have, tx_byte, seven, clocked, shift_edge,
    output tx_take, tx_busy, tx_line
  );
  modport rx (
    input seven, clocked, sample_edge, rx_line, rx_go,
    output rx_done, rx_byte, rx_busy
  );
endinterface : spsf_ser_if

`default_nettype wire

/* File: spsf_tx.sv */
// Transmit shifter for asynchronous and clocked serial modes
`timescale 1ns/1ps
`default_nettype none

module spsf_tx
  import spsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Status logic side
  spsf_ser_if.tx sif
);

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} spsf_tx_state_t;

  spsf_tx_state_t state;
  logic [9:0] shreg;
  logic [3:0] bits_left;
  logic [CNT_W-1:0] cnt;
  logic bit_end;
  logic last_bit;
  logic load;
  logic [9:0] frame;
  logic [3:0] frame_bits;

  assign bit_end = sif.clocked ? sif.shift_edge
                               : (cnt == CNT_W'(BIT_CYCLES - 1));
  assign last_bit = (state == TX_SEND) && bit_end && (bits_left == 4'h1);
  // Back to back bytes keep busy high with no idle gap
  assign load = sif.tx_have && ((state == TX_IDLE) || last_bit);
  assign sif.tx_take = load;
  assign sif.tx_busy = (state == TX_SEND);
  assign sif.tx_line = shreg[0];

  always_comb begin
    if (sif.clocked) begin
      frame = {2'h3, sif.tx_byte};
      frame_bits = FRAME_SYNC;
    end else if (sif.seven) begin
      frame = {2'h3, sif.tx_byte[6:0], 1'b0};
      frame_bits = FRAME_A7;
    end else begin
      frame = {1'b1, sif.tx_byte, 1'b0};
      frame_bits = FRAME_A8;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= TX_IDLE;
    end else if (load) begin
      state <= TX_SEND;
    end else if (last_bit) begin
      state <= TX_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shreg <= '1;
      bits_left <= 4'h0;
    end else if (load) begin
      shreg <= frame;
      bits_left <= frame_bits;
    end else if ((state == TX_SEND) && bit_end) begin
      shreg <= {1'b1, shreg[9:1]};
      bits_left <= bits_left - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || load || (state == TX_IDLE) || sif.clocked || bit_end) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

endmodule : spsf_tx

`default_nettype wire

/* File: spsf_rx.sv */
// Receive shifter for asynchronous and clocked serial modes
`timescale 1ns/1ps
`default_nettype none

module spsf_rx
  import spsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Status logic side
  spsf_ser_if.rx sif
);

  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } spsf_rx_state_t;

  spsf_rx_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [7:0] shreg;
  logic [3:0] bits_left;
  logic sample;
  logic mid_start;
  logic last_data;
  logic [7:0] shifted;
  logic done;

  assign sample = sif.clocked ? sif.sample_edge
                              : (cnt == CNT_W'(BIT_CYCLES - 1));
  assign mid_start = (cnt == CNT_W'(HALF_BIT_CYCLES - 1));
  assign last_data = (state == RX_DATA) && sample && (bits_left == 4'h1);
  assign shifted = {sif.rx_line, shreg[7:1]};
  assign sif.rx_busy = (state != RX_IDLE);
  assign sif.rx_byte = shreg;
  assign sif.rx_done = done;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= RX_IDLE;
    end else begin
      unique case (state)
        RX_IDLE: begin
          if (sif.clocked && sif.rx_go) begin
            state <= RX_DATA;
          end else if (!sif.clocked && !sif.rx_line) begin
            state <= RX_START;
          end
        end
        RX_START: begin
          // A glitch shorter than half a bit is not a start bit
          if (sif.clocked) begin
            state <= RX_IDLE;
          end else if (mid_start) begin
            state <= sif.rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (last_data) begin
            state <= sif.clocked ? RX_IDLE : RX_STOP;
          end
        end
        RX_STOP: begin
          if (sample) begin
            state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || (state == RX_IDLE) || sample ||
        ((state == RX_START) && mid_start)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shreg <= DATA_RESET;
      bits_left <= 4'h0;
    end else if (state == RX_IDLE) begin
      bits_left <= (sif.seven && !sif.clocked) ? RX_BITS7 : RX_BITS8;
    end else if ((state == RX_DATA) && sample) begin
      bits_left <= bits_left - 4'h1;
      if (last_data && sif.seven && !sif.clocked) begin
        shreg <= {1'b0, shifted[7:1]};
      end else begin
        shreg <= shifted;
      end
    end
  end

  // Framing errors are not checked; the byte is delivered regardless
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= (last_data && sif.clocked) ||
              ((state == RX_STOP) && sample && !sif.clocked);
    end
  end

endmodule : spsf_rx

`default_nettype wire

/* File: spsf_top.sv */
// Four-channel serial port status flags with register port and interrupt
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Overrun bit sets; receive buffer read clears
// - Async mode returns zero in bits 4, 1:0
// - Async transmit data write sets full bit
// - Transfer to shifter or async status write clears full
// - Transfer to shifter raises transmit interrupt if enabled
// - Data or status write clears transmit interrupt
// - Busy and shifter load on start bit edge
// - Async busy clears at end of stop
// - Busy falling with empty buffer latches interrupt
// - Clocked mode bit 7 shows receive full
// - Clocked mode returns zero in 6, 4, 1:0
// - Clocked full bit; interrupt when byte taken
// - Clocked busy bit shows shifting in progress
// - Clocked busy clears only when buffer empty
// - Two-bit mode field selects operating mode
// - Receive full rising sets receive interrupt
module spsf_top
  import spsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial pins, one bit per channel
  output logic [NUM_CHAN-1:0] ser_txd,
  input wire logic [NUM_CHAN-1:0] ser_rxd,
  input wire logic [NUM_CHAN-1:0] ser_clk_in,
  output logic [NUM_CHAN-1:0] ser_clk_out,
  output logic [NUM_CHAN-1:0] ser_clk_oe,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [NUM_CHAN-1:0] rxd_meta;
  logic [NUM_CHAN-1:0] rxd_sync;
  logic [NUM_CHAN-1:0] sclk_meta;
  logic [NUM_CHAN-1:0] sclk_sync;
  logic [NUM_CHAN-1:0] sclk_prev;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_meta <= '1;
      rxd_sync <= '1;
    end else begin
      rxd_meta <= ser_rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // Edge detection compares the second stage with the third
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_meta <= '0;
      sclk_sync <= '0;
      sclk_prev <= '0;
    end else begin
      sclk_meta <= ser_clk_in;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel event and read signals

  logic [NUM_CHAN-1:0] rx_evt;
  logic [NUM_CHAN-1:0] rx_drop;
  logic [NUM_CHAN-1:0] tx_evt;
  logic [NUM_CHAN-1:0] tx_drop;
  logic [7:0] data_word [NUM_CHAN];
  logic [7:0] status_word [NUM_CHAN];
  logic [7:0] ctrl_word [NUM_CHAN];
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Channels

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    spsf_ser_if sif ();

    logic [ADDR_W-1:0] base;
    logic wr_data;
    logic wr_stat;
    logic wr_ctrl;
    logic rd_data;
    logic [7:0] ctrl;
    logic [7:0] tx_hold;
    logic [7:0] rx_data;
    logic tx_full;
    logic rx_full;
    logic overrun;
    logic busy_q;
    logic busy_fall;
    logic is_async;
    logic int_en;
    spsf_mode_t mode;
    logic [CNT_W-1:0] sclk_cnt;
    logic sclk_int;
    logic sclk_run;
    logic sclk_half;
    logic int_rise;
    logic int_fall;
    logic ext_rise;
    logic ext_fall;

    assign base = STATUS_ADDR[i] - STAT_OFS;
    assign wr_data = reg_wr && (reg_addr == base + DATA_OFS);
    assign wr_stat = reg_wr && (reg_addr == base + STAT_OFS);
    assign wr_ctrl = reg_wr && (reg_addr == base + CTRL_OFS);
    assign rd_data = reg_rd && (reg_addr == base + DATA_OFS);

    assign mode = spsf_mode_t'(ctrl[CT_MODE_HI:CT_MODE_LO]);
    assign is_async = (mode == MODE_ASYNC8) || (mode == MODE_ASYNC7);
    assign int_en = (ctrl[CT_PRI_HI:CT_PRI_LO] != 2'h0);

    // Control: command bits act once and are not stored
    always_ff @(posedge clk) begin
      if (rst) begin
        ctrl <= CTRL_RESET;
      end else if (wr_ctrl) begin
        ctrl <= reg_wdata & CTRL_STORE_MASK;
      end
    end

    // Transmit holding register
    always_ff @(posedge clk) begin
      if (rst) begin
        tx_hold <= DATA_RESET;
      end else if (wr_data) begin
        tx_hold <= reg_wdata;
      end
    end

    // A new write wins over the transfer in the same cycle
    always_ff @(posedge clk) begin
      if (rst) begin
        tx_full <= 1'b0;
      end else if (wr_data) begin
        tx_full <= 1'b1;
      end else if (sif.tx_take) begin
        tx_full <= 1'b0;
      end else if (wr_stat && is_async) begin
        tx_full <= 1'b0;
      end
    end

    // Receive buffer; a byte arriving while full and not read in that cycle is dropped
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_data <= DATA_RESET;
        rx_full <= 1'b0;
        overrun <= 1'b0;
      end else begin
        if (sif.rx_done && (!rx_full || rd_data)) begin
          rx_data <= sif.rx_byte;
          rx_full <= 1'b1;
        end else if (rd_data) begin
          rx_full <= 1'b0;
        end
        if (sif.rx_done && rx_full && !rd_data) begin
          overrun <= 1'b1;
        end else if (rd_data) begin
          overrun <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        busy_q <= 1'b0;
      end else begin
        busy_q <= sif.tx_busy;
      end
    end

    assign busy_fall = busy_q && !sif.tx_busy && !tx_full;

    // Interrupt events and their documented clears
    assign rx_evt[i] = int_en && sif.rx_done && (!rx_full || rd_data);
    assign rx_drop[i] = rd_data;
    assign tx_evt[i] = int_en &&
                       ((sif.tx_take && !wr_data) || busy_fall);
    assign tx_drop[i] = wr_data || wr_stat;

    // Internal shift clock runs only while a transfer needs it
    // A started high phase runs out, so the far side sees a final fall
    assign sclk_run = (mode == MODE_CLK_INT) &&
                      (sif.tx_busy || sif.rx_busy || sclk_int);
    assign sclk_half = (sclk_cnt == CNT_W'(SCLK_HALF_CYCLES - 1));
    assign int_rise = sclk_run && sclk_half && !sclk_int;
    assign int_fall = sclk_run && sclk_half && sclk_int;
    assign ext_rise = sclk_sync[i] && !sclk_prev[i];
    assign ext_fall = !sclk_sync[i] && sclk_prev[i];

    always_ff @(posedge clk) begin
      if (rst || !sclk_run) begin
        sclk_cnt <= '0;
        sclk_int <= 1'b0;
      end else if (sclk_half) begin
        sclk_cnt <= '0;
        sclk_int <= !sclk_int;
      end else begin
        sclk_cnt <= sclk_cnt + CNT_W'(1);
      end
    end

    // Data shifts on the falling edge and is sampled on the rising edge
    assign sif.shift_edge = (mode == MODE_CLK_INT) ? int_fall
                          : (mode == MODE_CLK_EXT) ? ext_fall : 1'b0;
    assign sif.sample_edge = (mode == MODE_CLK_INT) ? int_rise
                           : (mode == MODE_CLK_EXT) ? ext_rise : 1'b0;
    assign sif.tx_have = tx_full;
    assign sif.tx_byte = tx_hold;
    assign sif.seven = (mode == MODE_ASYNC7);
    assign sif.clocked = !is_async;
    assign sif.rx_line = rxd_sync[i];
    // In clocked modes, reading the data register or the receive command starts a byte
    assign sif.rx_go = !is_async &&
                       (rd_data || (wr_ctrl && reg_wdata[CMD_RX_BIT]));

    spsf_tx u_tx (
      .clk(clk),
      .rst(rst),
      .sif(sif)
    );

    spsf_rx u_rx (
      .clk(clk),
      .rst(rst),
      .sif(sif)
    );

    assign ser_txd[i] = sif.tx_line;
    assign ser_clk_out[i] = sclk_int;
    assign ser_clk_oe[i] = (mode == MODE_CLK_INT);

    // Bit 6 reads zero: address bit capture is not provided
    assign status_word[i] = {
      rx_full,
      1'b0,
      overrun,
      1'b0,
      tx_full,
      sif.tx_busy,
      2'h0
    };
    assign data_word[i] = rx_data;
    assign ctrl_word[i] = ctrl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  logic [IRQ_W-1:0] w1c;

  assign w1c = (reg_wr && (reg_addr == IRQ_STAT_ADDR)) ? reg_wdata
                                                       : IRQ_RESET;

  // An event in the clearing cycle keeps its bit set
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat <= IRQ_RESET;
    end else begin
      for (int k = 0; k < NUM_CHAN; k++) begin
        if (rx_evt[k]) begin
          irq_stat[2*k] <= 1'b1;
        end else if (rx_drop[k] || w1c[2*k]) begin
          irq_stat[2*k] <= 1'b0;
        end
        if (tx_evt[k]) begin
          irq_stat[2*k+1] <= 1'b1;
        end else if (tx_drop[k] || w1c[2*k+1]) begin
          irq_stat[2*k+1] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask <= IRQ_RESET;
    end else if (reg_wr && (reg_addr == IRQ_MASK_ADDR)) begin
      irq_mask <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    for (int k = 0; k < NUM_CHAN; k++) begin
      if (reg_addr == STATUS_ADDR[k] - STAT_OFS + DATA_OFS) begin
        next_rdata = data_word[k];
      end
      if (reg_addr == STATUS_ADDR[k]) begin
        next_rdata = status_word[k];
      end
      if (reg_addr == STATUS_ADDR[k] - STAT_OFS + CTRL_OFS) begin
        next_rdata = ctrl_word[k];
      end
    end
    if (reg_addr == IRQ_STAT_ADDR) begin
      next_rdata = irq_stat;
    end
    if (reg_addr == IRQ_MASK_ADDR) begin
      next_rdata = irq_mask;
    end
  end

  // Read data stand for one cycle only and are zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

endmodule : spsf_top

`default_nettype wire

/* File: spsf_monitor.sv */
// Port-level assertions for the serial port status flag block
`timescale 1ns/1ps
`default_nettype none

module spsf_monitor
  import spsf_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Line and interrupt
  input wire logic [NUM_CHAN-1:0] ser_txd,
  input wire logic [NUM_CHAN-1:0] ser_clk_out,
  input wire logic [NUM_CHAN-1:0] ser_clk_oe,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic st_rd;
  logic [1:0] wmode;
  // Any of the four status addresses
  assign st_rd = reg_rd && reg_addr[15:6] == 10'h003 && reg_addr[3:0] == 4'h3;
  assign wmode = reg_wdata[3:2];

  ////////////////////////////////////////
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst |=> !irq && ser_txd == 4'hf && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  AST_ASYNC_ZERO: assert property (st_rd |=> (reg_rdata & 8'h13) == 8'h00)
    else $error("status bits 4 or 1:0 not zero");
  AST_CLK_ZERO: assert property (st_rd |=> (reg_rdata & 8'h53) == 8'h00)
    else $error("status bits 6, 4 or 1:0 not zero");
  AST_TX_FULL_SET: assert property (reg_wr && reg_addr == 16'h00c0 &&
    !ser_clk_oe[0] ##1 reg_rd && reg_addr == SERIAL_A_STATUS
    |=> reg_rdata[ST_TX_FULL]) else $error("full bit not set by write");
  AST_MODE_OE: assert property (reg_wr && reg_addr == 16'h00c4 |=>
    ser_clk_oe[0] == ($past(wmode) == 2'b11))
    else $error("clock enable does not follow mode");
  AST_MASK_OFF: assert property (reg_wr && reg_addr == IRQ_MASK_ADDR &&
    reg_wdata == 8'h00 |=> ##1 !irq) else $error("irq with all masked");
  AST_BIT_HOLD: assert property ($fell(ser_txd[0]) && !ser_clk_oe[0]
    |=> (!ser_txd[0]) [*8]) else $error("async bit too short");
  AST_SCLK_HALF: assert property ($rose(ser_clk_out[0])
    |=> $stable(ser_clk_out[0]) [*8]) else $error("shift clock too fast");
  AST_SCLK_IDLE: assert property (!ser_clk_oe[0] && !$past(ser_clk_oe[0])
    |-> !ser_clk_out[0]) else $error("shift clock runs while disabled");

  cover property (st_rd ##1 reg_rdata[ST_RX_FULL]);
  cover property ($rose(irq));
  cover property ($rose(ser_clk_out[0]));
endmodule : spsf_monitor

bind spsf_top spsf_monitor u_mon (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ser_txd(ser_txd), .ser_clk_out(ser_clk_out),
  .ser_clk_oe(ser_clk_oe), .irq(irq)
);

`default_nettype wire

/* File: spsf_remote.sv */
// Remote serial device on the channel A line
`timescale 1ns/1ps
`default_nettype none

module spsf_remote
  import spsf_pkg::*;
(
  // Clock
  input wire logic clk,
  // Line
  input wire logic txd,
  input wire logic sclk,
  output logic rxd,
  // Bench control
  input wire logic go_async,
  input wire logic go_clk,
  input wire logic listen,
  input wire logic [7:0] tx_val,
  output logic got,
  output logic [7:0] got_val
);
  int i;
  int j;
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_val = 8'h00;
  end

  ////////////////////////////////////////
  // Sender; line falls back to its pulled-up idle level
  always @(posedge clk) begin
    if (go_async) begin
      rxd <= 1'b0;
      for (i = 0; i < 9; i++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        rxd <= (i < 8) ? tx_val[i] : 1'b1;
      end
    end else if (go_clk) begin
      rxd <= tx_val[0];
      for (i = 1; i < 9; i++) begin
        @(negedge sclk);
        rxd <= (i < 8) ? tx_val[i] : 1'b1;
      end
    end
  end

  // Receiver samples mid bit, LSB first
  always @(posedge clk) begin
    got <= 1'b0;
    if (listen && !txd) begin
      repeat (HALF_BIT_CYCLES) @(posedge clk);
      for (j = 0; j < 9; j++) begin
        repeat (BIT_CYCLES) @(posedge clk);
        if (j < 8) got_val[j] <= txd;
      end
      got <= 1'b1;
    end
  end
endmodule : spsf_remote

`default_nettype wire

/* File: serial_port_status_flags_tb_top.sv */
// Self-checking bench for the serial port status flags
`timescale 1ns/1ps
`default_nettype none

module serial_port_status_flags_tb_top;
  import spsf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, got_val, b;
  logic [3:0] ser_txd, ser_clk_out, ser_clk_oe;
  logic irq, rxd_a, got;
  logic go_async = 1'b0;
  logic go_clk = 1'b0;
  logic listen = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] tx_val = 8'h00;
  logic [15:0] eq;
  logic [15:0] exp_rd[$];
  logic [7:0] exp_ser[$];
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int k;

  spsf_top dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ser_txd(ser_txd), .ser_rxd({3'h7, rxd_a}), .ser_clk_in(4'h0),
    .ser_clk_out(ser_clk_out), .ser_clk_oe(ser_clk_oe), .irq(irq)
  );
  spsf_remote u_far (
    .clk(clk), .txd(ser_txd[0]), .sclk(ser_clk_out[0]), .rxd(rxd_a),
    .go_async(go_async), .go_clk(go_clk), .listen(listen),
    .tx_val(tx_val), .got(got), .got_val(got_val)
  );

  always #50 clk = ~clk;

  ////////////////////////////////////////
  // Strobe stays up between ops so back-to-back cycles need no gap
  task automatic op(input logic w, input logic [15:0] a,
                    input logic [7:0] d, input logic [15:0] e);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) exp_rd.push_back(e);
    @(posedge clk);
  endtask : op
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    op(1'b1, a, d, 16'h0000);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    op(1'b0, a, 8'h00, {8'hff, e});
  endtask : rd
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  // Result watcher; read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    cycles++;
    if (rd_seen) begin
      eq = exp_rd.pop_front();
      check("reg_rdata", reg_rdata & eq[15:8], eq[7:0]);
    end
    if (got) check("line byte", got_val, exp_ser.pop_front());
    rd_seen <= reg_rd;
    if (cycles == 60000) begin
      mismatches++;
      stop_test();
    end
  end

  ////////////////////////////////////////
  initial begin
    void'($urandom(10));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(16'h0050, 8'h00);
    rd(IRQ_STAT_ADDR, 8'h00);
    for (k = 0; k < 4; k++) begin
      rd(STATUS_ADDR[k], 8'h00);
      wr(16'h00c4, {4'h0, k[1:0], 2'b01});
      rd(16'h00c4, {4'h0, k[1:0], 2'b01});
    end
    idle(1);
    $display("test reset and map done");
    b = 8'($urandom);
    wr(IRQ_MASK_ADDR, 8'hff);
    wr(16'h00c0, b);
    idle(5);
    op(1'b0, 16'h00c3, 8'h00, {8'h57, 8'h04});
    idle(1000);
    rd(16'h00c3, 8'h00);
    rd(IRQ_STAT_ADDR, 8'h02);
    wr(IRQ_STAT_ADDR, 8'hff);
    tx_val <= 8'($urandom);
    go_clk <= 1'b1;
    wr(16'h00c4, 8'h4d);
    go_clk <= 1'b0;
    idle(1000);
    rd(16'h00c3, 8'h80);
    rd(IRQ_STAT_ADDR, 8'h01);
    rd(16'h00c0, tx_val);
    idle(1000);
    wr(16'h00c4, 8'h01);
    rd(16'h00c0, 8'hff);
    rd(16'h00c3, 8'h00);
    wr(IRQ_STAT_ADDR, 8'hff);
    idle(2);
    $display("test clocked mode done");
    listen <= 1'b1;
    b = 8'($urandom);
    exp_ser.push_back(b);
    wr(16'h00c0, b);
    op(1'b0, 16'h00c3, 8'h00, {8'h08, 8'h08});
    idle(3);
    rd(IRQ_STAT_ADDR, 8'h02);
    check("irq", {7'h00, irq}, 8'h01);
    rd(16'h00c3, 8'h04);
    wr(16'h00c3, 8'h5a);
    rd(IRQ_STAT_ADDR, 8'h00);
    wr(16'h00c0, ~b);
    rd(16'h00c3, 8'h0c);
    wr(16'h00c3, 8'ha5);
    rd(16'h00c3, 8'h04);
    idle(10600);
    rd(16'h00c3, 8'h00);
    rd(IRQ_STAT_ADDR, 8'h02);
    wr(IRQ_STAT_ADDR, 8'hff);
    idle(1);
    $display("test async transmit done");
    b = 8'($urandom);
    for (k = 0; k < 2; k++) begin
      tx_val <= k[0] ? ~b : b;
      go_async <= 1'b1;
      idle(1);
      go_async <= 1'b0;
      idle(10600);
      rd(16'h00c3, k[0] ? 8'ha0 : 8'h80);
      rd(IRQ_STAT_ADDR, 8'h01);
    end
    rd(16'h00c0, b);
    rd(16'h00c3, 8'h00);
    rd(IRQ_STAT_ADDR, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h00);
    idle(3);
    check("irq", {7'h00, irq}, 8'h00);
    check("notes left", 8'(exp_rd.size() + exp_ser.size()), 8'h00);
    $display("test async receive done");
    stop_test();
  end
endmodule : serial_port_status_flags_tb_top

`default_nettype wire
